//--- include/pabio_pkg.sv
package pabio_pkg;
   localparam int PABIO_WIDTH = 8;
   localparam int PABIO_AW = 3;
   // Register offsets (word addresses on the plain register port).
   localparam logic [2:0] PABIO_PIN_LEVEL_OFS = 3'h0;
   localparam logic [2:0] PABIO_LATCH_OFS = 3'h1;
   localparam logic [2:0] PABIO_DIR_OFS = 3'h2;
   localparam logic [2:0] PABIO_ADC_CFG_OFS = 3'h3;
   localparam logic [2:0] PABIO_CMP_CFG_OFS = 3'h4;
   localparam logic [2:0] PABIO_OSC_CFG_OFS = 3'h5;
   // Reset values.
   localparam logic [7:0] PABIO_LATCH_RST = 8'h00;
   localparam logic [7:0] PABIO_DIR_RST = 8'hFF;
   localparam logic [7:0] PABIO_ADC_CFG_RST = 8'h2F;
   localparam logic [7:0] PABIO_CMP_CFG_RST = 8'h00;
   localparam logic [7:0] PABIO_OSC_CFG_RST = 8'h00;
   // Comparator config field positions.
   localparam int PABIO_CMP_C1OE_BIT = 0;
   localparam int PABIO_CMP_C2OE_BIT = 1;
   localparam int PABIO_CMP_VREFOE_BIT = 2;
   localparam int PABIO_CMP_ON_BIT = 3;
   // Analog-capable pin mask: pins 0..3 and 5.
   localparam logic [7:0] PABIO_ANALOG_MASK = 8'h2F;
   // Pin numbers with alternate functions.
   localparam int PABIO_PIN_REF = 2;
   localparam int PABIO_PIN_C1 = 4;
   localparam int PABIO_PIN_C2 = 5;
   localparam int PABIO_PIN_OSC2 = 6;
   localparam int PABIO_PIN_OSC1 = 7;
   // Oscillator mode codes, field in bits 2:0 of the oscillator register.
   typedef enum logic [2:0] {
      PABIO_OSC_XTAL = 3'h0,
      PABIO_OSC_RC_CLKOUT = 3'h1,
      PABIO_OSC_RC_IO = 3'h2,
      PABIO_OSC_INT_IO = 3'h3,
      PABIO_OSC_INT_CLKOUT = 3'h4,
      PABIO_OSC_EC_CLKOUT = 3'h5,
      PABIO_OSC_EC_IO = 3'h6
   } pabio_osc_e;
   // Cycle clock divides the oscillator clock by four.
   localparam int PABIO_CYCLE_DIV = 4;
endpackage

//--- core/pabio_sync.sv
`timescale 1ns/100ps
module pabio_sync #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Data
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   import pabio_pkg::*;

   if (WIDTH < 1)
   begin : g_width_check
      $error("pabio_sync: WIDTH must be at least 1");
   end

   logic [WIDTH-1:0] stageOne_q;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stageOne_q <= '0;
         syncOut <= '0;
      end
      else
      begin
         stageOne_q <= asyncIn;
         syncOut <= stageOne_q;
      end
   end
endmodule

//--- core/pabio_cycle_clk.sv
`timescale 1ns/100ps
module pabio_cycle_clk #(
   parameter int DIV = pabio_pkg::PABIO_CYCLE_DIV
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Cycle clock, half period high
   output logic cycleClk
);
   import pabio_pkg::*;
   localparam int CW = $clog2(DIV);
   logic [CW-1:0] count_q;

   // An odd divider cannot give equal high and low halves.
   if (DIV < 2 || (DIV % 2) != 0)
   begin : g_div_check
      $error("pabio_cycle_clk: DIV must be even and at least 2");
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count_q <= '0;
         cycleClk <= 1'b0;
      end
      else
      begin
         count_q <= (count_q == CW'(DIV - 1)) ? '0 : count_q + 1'b1;
         cycleClk <= (count_q < CW'(DIV / 2));
      end
   end
endmodule

//--- core/pabio_port.sv
`timescale 1ns/100ps
// Behaviour
// - Direction bit 1 puts the pin driver in high impedance, except pin 6 in clock-out modes.
// - Direction bit 0 drives the pin from the output latch.
// - Pin-level register reads pins; writing it updates the latch.
// - Latch register is separate and reads back the latch value.
// - Eight pins, each with own direction and latch bit.
// - Pins 6 and 7 not assigned to port read zero everywhere.
// - Converter config selects analog pins 0-3,5; analog disables input.
// - After reset pins 0-3,5 analog reading zero, pin 4 digital.
// - Direction bits keep controlling drivers in analog mode.
// - Enabled comparator outputs replace latch on pins 4 and 5.
// - Reference output on pin 2 disables its digital input and output.
// - Analog mode does not block the output driver.
// - Pin 6 is a port pin only in the three I/O oscillator modes.
// - Pin 7 digital path is off in external oscillator modes.
// - Pin 6 outputs cycle clock in clock-out oscillator modes.
// - Pin 4 feeds the timer clock input when an input.
// - Pin 5 feeds the serial slave select when direction is 1.
module pabio_port #(
   parameter int WIDTH = pabio_pkg::PABIO_WIDTH
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Register port
   input wire logic [pabio_pkg::PABIO_AW-1:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdata,
   // Pads
   input wire logic [WIDTH-1:0] padIn,
   output logic [WIDTH-1:0] padOut,
   output logic [WIDTH-1:0] padOe,
   // Peripheral hookups
   input wire logic comparatorOneOutput,
   input wire logic comparatorTwoOutput,
   output logic timerExtClockInput,
   output logic serialSlaveSelectN,
   output logic [WIDTH-1:0] analogSelect,
   output logic comparatorsOn,
   output logic comparatorReferenceOutput
);
   import pabio_pkg::*;

   // The register map and the pin functions are fixed at eight pins.
   if (WIDTH != PABIO_WIDTH)
   begin : g_width_check
      $error("pabio_port: WIDTH must be 8");
   end

   logic [7:0] latch_q;
   logic [7:0] dir_q;
   logic [7:0] adcCfg_q;
   logic [7:0] cmpCfg_q;
   logic [7:0] oscCfg_q;
   logic [7:0] pinSync;
   logic cycleClk;
   logic [7:0] portPinEn;
   wire logic [7:0] digInEn;
   wire logic [7:0] pinLevel;
   wire logic [7:0] drvVal;
   wire logic [7:0] drvEn;
   logic [7:0] readValue;
   logic selPinLevel;
   logic selLatch;
   logic selDir;
   logic selAdcCfg;
   logic selCmpCfg;
   logic selOscCfg;
   logic wrLatch;
   logic wrDir;
   logic wrAdcCfg;
   logic wrCmpCfg;
   logic wrOscCfg;
   logic pin6Port;
   logic pin6ClkOut;
   logic pin7Port;
   pabio_osc_e oscMode;

   pabio_sync #(.WIDTH(8)) uSync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .asyncIn(padIn),
      .syncOut(pinSync)
   );

   pabio_cycle_clk #(.DIV(PABIO_CYCLE_DIV)) uCycle (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .cycleClk(cycleClk)
   );

   // Codes outside the enumeration fall to the default branch below and
   // leave both oscillator pins to the oscillator.
   assign oscMode = pabio_osc_e'(oscCfg_q[2:0]);

   always_comb
   begin
      pin6Port = 1'b0;
      pin6ClkOut = 1'b0;
      pin7Port = 1'b0;
      case (oscMode)
         PABIO_OSC_RC_IO, PABIO_OSC_EC_IO:
         begin
            pin6Port = 1'b1;
         end
         PABIO_OSC_INT_IO:
         begin
            pin6Port = 1'b1;
            pin7Port = 1'b1;
         end
         PABIO_OSC_INT_CLKOUT:
         begin
            pin6ClkOut = 1'b1;
            pin7Port = 1'b1;
         end
         PABIO_OSC_RC_CLKOUT, PABIO_OSC_EC_CLKOUT:
         begin
            pin6ClkOut = 1'b1;
         end
         default:
         begin
            pin6Port = 1'b0;
         end
      endcase
   end

   // Pins 6 and 7 belong to the oscillator unless freed by the mode.
   always_comb
   begin
      portPinEn = 8'hFF;
      portPinEn[PABIO_PIN_OSC2] = pin6Port;
      portPinEn[PABIO_PIN_OSC1] = pin7Port;
   end

   // Register selects, decoded once for both the write and the read side.
   assign selPinLevel = (regAddr == PABIO_PIN_LEVEL_OFS);
   assign selLatch = (regAddr == PABIO_LATCH_OFS);
   assign selDir = (regAddr == PABIO_DIR_OFS);
   assign selAdcCfg = (regAddr == PABIO_ADC_CFG_OFS);
   assign selCmpCfg = (regAddr == PABIO_CMP_CFG_OFS);
   assign selOscCfg = (regAddr == PABIO_OSC_CFG_OFS);

   // Both the pin-level and the latch index write the latch; indices six
   // and seven decode to nothing, so writes there are dropped.
   assign wrLatch = regWrite & (selPinLevel | selLatch);
   assign wrDir = regWrite & selDir;
   assign wrAdcCfg = regWrite & selAdcCfg;
   assign wrCmpCfg = regWrite & selCmpCfg;
   assign wrOscCfg = regWrite & selOscCfg;

   // Each pin resolves drive value, drive enable and digital input alone.
   // Special functions are picked by fixed pin numbers, so on ordinary
   // pins their muxes fold away to plain latch and direction logic.
   for (genvar p = 0; p < PABIO_WIDTH; p++)
   begin : g_pin
      localparam bit IS_REF = (p == PABIO_PIN_REF);
      localparam bit IS_CMP_ONE = (p == PABIO_PIN_C1);
      localparam bit IS_CMP_TWO = (p == PABIO_PIN_C2);
      localparam bit IS_CLK = (p == PABIO_PIN_OSC2);
      logic analogHere;
      logic refHere;
      logic cmpHere;
      logic cmpVal;
      logic clkHere;
      logic portDrive;

      // Analog selection gates the input only, never the driver.
      assign analogHere = adcCfg_q[p] & PABIO_ANALOG_MASK[p];
      assign refHere = IS_REF & cmpCfg_q[PABIO_CMP_VREFOE_BIT];
      assign clkHere = IS_CLK & pin6ClkOut;

      always_comb
      begin
         cmpHere = 1'b0;
         cmpVal = 1'b0;
         if (IS_CMP_ONE)
         begin
            cmpHere = cmpCfg_q[PABIO_CMP_C1OE_BIT];
            cmpVal = comparatorOneOutput;
         end
         else if (IS_CMP_TWO)
         begin
            cmpHere = cmpCfg_q[PABIO_CMP_C2OE_BIT];
            cmpVal = comparatorTwoOutput;
         end
      end

      // Direction, port ownership, reference and clock-out set the driver, whatever the analog selection.
      assign portDrive = ~dir_q[p] & portPinEn[p];
      assign drvEn[p] = clkHere | (portDrive & ~refHere);
      assign drvVal[p] = clkHere ? cycleClk
         : (cmpHere ? cmpVal : latch_q[p]);
      assign digInEn[p] = portPinEn[p] & ~analogHere & ~refHere;
   end

   assign pinLevel = pinSync & digInEn;

   // Pad drivers are registered, so outputs follow settings one cycle late.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         padOut <= '0;
      else
         padOut <= drvVal;
   end

   // Reset leaves every driver off, so no pin is driven before software
   // has chosen a direction.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         padOe <= '0;
      else
         padOe <= drvEn;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         timerExtClockInput <= 1'b0;
      else
         timerExtClockInput <= dir_q[PABIO_PIN_C1]
            & pinSync[PABIO_PIN_C1];
   end

   // Slave select idles inactive while pin five drives, so the serial
   // block never takes the port's own output for a select.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         serialSlaveSelectN <= 1'b1;
      else if (dir_q[PABIO_PIN_C2])
         serialSlaveSelectN <= pinSync[PABIO_PIN_C2];
      else
         serialSlaveSelectN <= 1'b1;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         analogSelect <= '0;
      else
         analogSelect <= adcCfg_q & PABIO_ANALOG_MASK;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         comparatorsOn <= 1'b0;
      else
         comparatorsOn <= cmpCfg_q[PABIO_CMP_ON_BIT];
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         comparatorReferenceOutput <= 1'b0;
      else
         comparatorReferenceOutput <= cmpCfg_q[PABIO_CMP_VREFOE_BIT];
   end

   // Latch: written through either the pin-level or the latch address.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         latch_q <= PABIO_LATCH_RST;
      else if (wrLatch)
         latch_q <= regWdata;
   end

   // Direction resets to all inputs, so nothing drives until software asks.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         dir_q <= PABIO_DIR_RST;
      else if (wrDir)
         dir_q <= regWdata;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         adcCfg_q <= PABIO_ADC_CFG_RST;
      else if (wrAdcCfg)
         adcCfg_q <= regWdata & PABIO_ANALOG_MASK;
   end

   // Only the four defined control bits are kept; the rest read back zero.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         cmpCfg_q <= PABIO_CMP_CFG_RST;
      else if (wrCmpCfg)
         cmpCfg_q <= {4'h0, regWdata[3:0]};
   end

   // Mode bits only; the upper bits read back zero.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         oscCfg_q <= PABIO_OSC_CFG_RST;
      else if (wrOscCfg)
         oscCfg_q <= {5'h00, regWdata[2:0]};
   end

   // Idle cycles and unmapped indices both read as zero, so the master can
   // take the data bus without qualifying it.
   always_comb
   begin
      readValue = 8'h00;
      if (selPinLevel)
         readValue = pinLevel;
      else if (selLatch)
         readValue = latch_q & portPinEn;
      else if (selDir)
         readValue = dir_q & portPinEn;
      else if (selAdcCfg)
         readValue = adcCfg_q;
      else if (selCmpCfg)
         readValue = cmpCfg_q;
      else if (selOscCfg)
         readValue = oscCfg_q;
   end

   // Read data stands only in the cycle after the read strobe.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         regRdata <= 8'h00;
      else if (regRead)
         regRdata <= readValue;
      else
         regRdata <= 8'h00;
   end
endmodule

//--- test/pabio_port_assertions.sv
`timescale 1ns/100ps
module pabio_port_assertions #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Register port
   input wire logic [pabio_pkg::PABIO_AW-1:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regRdata,
   // Pads and hookups
   input wire logic [WIDTH-1:0] padOut,
   input wire logic [WIDTH-1:0] padOe,
   input wire logic timerExtClockInput,
   input wire logic serialSlaveSelectN,
   input wire logic [WIDTH-1:0] analogSelect,
   input wire logic comparatorsOn,
   input wire logic comparatorReferenceOutput
);
   import pabio_pkg::*;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   // A write lands at its edge and reaches the pads one edge later.
   sequence s_wr(logic [2:0] a);
      regWrite && regAddr == a;
   endsequence
   // No second write in between, so either register depth passes.
   sequence s_cmp_held;
      s_wr(PABIO_CMP_CFG_OFS) ##1 !(regWrite && regAddr == PABIO_CMP_CFG_OFS);
   endsequence
   chk_dir_hiz: assert property (s_wr(PABIO_DIR_OFS) |-> ##2
      padOe[1:0] == ~$past(regWdata[1:0], 2))
      else $error("enable not from direction");
   chk_latch_drive: assert property (
      regWrite && regAddr <= PABIO_LATCH_OFS |-> ##2
      (!padOe[0] || padOut[0] == $past(regWdata[0], 2)))
      else $error("drive not from latch");
   chk_read_idle: assert property (!regRead |=> regRdata == 8'h00)
      else $error("read data out of slot");
   chk_analog_copy: assert property (
      s_wr(PABIO_ADC_CFG_OFS) |-> ##2
      analogSelect == ($past(regWdata, 2) & PABIO_ANALOG_MASK))
      else $error("analog select wrong");
   chk_cmp_on: assert property (
      s_cmp_held |=> comparatorsOn == $past(regWdata[3], 2))
      else $error("comparator enable wrong");
   chk_ref_enable: assert property (
      s_cmp_held |=> comparatorReferenceOutput == $past(regWdata[2], 2))
      else $error("reference enable wrong");
   chk_ref_pin_off: assert property (
      comparatorReferenceOutput && $past(comparatorReferenceOutput)
      |-> !padOe[2])
      else $error("pin 2 driven with reference");
   chk_ss_idle: assert property (
      padOe[5] && $past(padOe[5]) |-> serialSlaveSelectN)
      else $error("slave select on output pin");
   chk_timer_off: assert property (
      padOe[4] && $past(padOe[4]) |-> !timerExtClockInput)
      else $error("timer clock on output pin");
endmodule
bind pabio_port pabio_port_assertions #(.WIDTH(WIDTH)) u_chk (
   .core_clk, .rst_n, .regAddr, .regWdata, .regWrite, .regRead,
   .regRdata, .padOut, .padOe, .timerExtClockInput, .serialSlaveSelectN,
   .analogSelect, .comparatorsOn, .comparatorReferenceOutput);

//--- test/pabio_pad_model.sv
`timescale 1ns/100ps
module pabio_pad_model (
   // Device side
   input wire logic [7:0] padOut,
   input wire logic [7:0] padOe,
   // Outside source
   input wire logic [7:0] extVal,
   output logic [7:0] padIn
);
   // An undriven pin follows the outside source, never the last drive.
   assign padIn = (padOut & padOe) | (extVal & ~padOe);
endmodule

//--- test/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   import pabio_pkg::*;
   logic core_clk, rst_n, regWrite, regRead;
   logic rdPend = 1'b0;
   logic cmpOne, cmpTwo, tmrClk, ssN, cmpOn, refOut;
   logic [2:0] regAddr;
   logic [7:0] regWdata, regRdata, padIn, padOut, padOe, extVal;
   logic [7:0] analogSelect, r, d, e, m;
   logic [7:0] expQ[$];
   int errTotal, nTests, i;
   pabio_port uut (.core_clk, .rst_n, .regAddr, .regWdata, .regWrite,
      .regRead, .regRdata, .padIn, .padOut, .padOe,
      .comparatorOneOutput(cmpOne), .comparatorTwoOutput(cmpTwo),
      .timerExtClockInput(tmrClk), .serialSlaveSelectN(ssN),
      .analogSelect, .comparatorsOn(cmpOn),
      .comparatorReferenceOutput(refOut));
   pabio_pad_model pads (.padOut, .padOe, .extVal, .padIn);
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   task automatic chk(input string n, input logic [7:0] x,
      input logic [7:0] g);
      nTests++;
      if (g !== x)
      begin
         errTotal++;
         $display("Error %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic endOfTest();
      if (errTotal == 0 && nTests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic idle(input int n);
      regWrite <= 1'b0;
      regRead <= 1'b0;
      repeat (n) @(posedge core_clk);
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      regAddr <= a;
      regWdata <= v;
      regWrite <= 1'b1;
      regRead <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] x);
      regAddr <= a;
      regRead <= 1'b1;
      regWrite <= 1'b0;
      expQ.push_back(x);
      @(posedge core_clk);
   endtask
   // Read data stand only in the cycle after the strobe.
   always @(posedge core_clk)
   begin
      if (rdPend && expQ.size() == 0)
         chk("readQueue", 8'h01, 8'h00);
      else if (rdPend)
         chk("regRdata", expQ.pop_front(), regRdata);
      rdPend <= regRead & rst_n;
   end
   initial
   begin
      rst_n = 1'b0;
      {regAddr, regWdata, regWrite, regRead} = '0;
      {cmpOne, cmpTwo, errTotal, nTests} = '0;
      extVal = 8'h10;
      r = 8'($urandom(79014));
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      rd(PABIO_LATCH_OFS, 8'h00);
      rd(PABIO_DIR_OFS, 8'h3F);
      rd(PABIO_ADC_CFG_OFS, 8'h2F);
      rd(PABIO_PIN_LEVEL_OFS, 8'h10);
      rd(3'h6, 8'h00);
      idle(2);
      chk("analogSelect", 8'h2F, analogSelect);
      chk("padOe", 8'h00, padOe);
      wr(PABIO_OSC_CFG_OFS, 8'h03);
      wr(PABIO_CMP_CFG_OFS, 8'h00);
      wr(PABIO_ADC_CFG_OFS, 8'h00);
      repeat (6)
      begin
         r = 8'($urandom());
         d = 8'($urandom());
         e = 8'($urandom());
         extVal <= e;
         wr(PABIO_PIN_LEVEL_OFS, r);
         wr(PABIO_DIR_OFS, d);
         idle(4);
         chk("padOe", ~d, padOe);
         chk("padOut", r & ~d, padOut & ~d);
         rd(PABIO_LATCH_OFS, r);
         rd(PABIO_PIN_LEVEL_OFS, (r & ~d) | (e & d));
      end
      wr(PABIO_DIR_OFS, 8'h00);
      wr(PABIO_ADC_CFG_OFS, 8'hFF);
      idle(4);
      chk("padOe", 8'hFF, padOe);
      chk("analogSelect", 8'h2F, analogSelect);
      rd(PABIO_PIN_LEVEL_OFS, r & 8'hD0);
      cmpOne <= ~r[4];
      cmpTwo <= ~r[5];
      wr(PABIO_CMP_CFG_OFS, 8'h0F);
      idle(4);
      m = r ^ 8'h30;
      chk("padOe", 8'hFB, padOe);
      chk("padOut", m & 8'hFB, padOut & 8'hFB);
      chk("cmpFlags", 8'h03, {6'h00, cmpOn, refOut});
      rd(PABIO_PIN_LEVEL_OFS, m & 8'hD0);
      wr(PABIO_CMP_CFG_OFS, 8'h00);
      wr(PABIO_DIR_OFS, 8'hFF);
      extVal <= 8'hFF;
      for (i = 0; i < 8; i++)
      begin
         wr(PABIO_OSC_CFG_OFS, 8'(i));
         idle(4);
         m = 8'h3F;
         m[6] = i inside {2, 3, 6};
         m[7] = i inside {3, 4};
         rd(PABIO_DIR_OFS, m);
         rd(PABIO_PIN_LEVEL_OFS, m & 8'hD0);
         idle(1);
         e = 8'h00;
         repeat (4)
         begin
            @(posedge core_clk);
            e = e + 8'(padOut[6]);
         end
         chk("clkOe", 8'(i inside {1, 4, 5}), 8'(padOe[6]));
         if (padOe[6] === 1'b1)
            chk("clkHigh", 8'h02, e);
      end
      wr(PABIO_ADC_CFG_OFS, 8'h00);
      extVal <= 8'h10;
      idle(5);
      chk("timer", 8'h01, 8'(tmrClk));
      chk("slaveSel", 8'h00, 8'(ssN));
      wr(PABIO_DIR_OFS, 8'h00);
      wr(3'h7, 8'hFF);
      rd(3'h7, 8'h00);
      idle(3);
      chk("timer", 8'h00, 8'(tmrClk));
      chk("slaveSel", 8'h01, 8'(ssN));
      chk("readQueue", 8'h00, 8'(expQ.size()));
      endOfTest();
   end
endmodule
